// >>> rtl/lesf_pkg.sv
// Constants shared by the link event status flag block
package lesf_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0]  OFS_STATUS  = 8'h20;
	localparam logic [7:0]  OFS_ENABLE  = 8'h24;
	localparam logic [7:0]  OFS_GLOBAL  = 8'h28;
	localparam logic [7:0]  OFS_ERRQ    = 8'h2C;
	// ----------------------------------------
	// Flag bit positions
	// ----------------------------------------
	localparam int          BIT_NO_CREDIT = 9;
	localparam int          BIT_RTB_FULL  = 8;
	localparam int          BIT_ERQ_OVF   = 6;
	localparam int          BIT_ERQ_RX    = 5;
	localparam int          BIT_FATAL     = 4;
	localparam int          BIT_REMOTE    = 3;
	localparam int          BIT_SEQ       = 2;
	localparam int          BIT_LEN       = 1;
	localparam int          BIT_CRC       = 0;
	localparam int          BIT_GLOBAL    = 0;
	localparam int          BIT_ERQ_VALID = 31;
	// Implemented flag bits; bit 7 and bits 10 and upward read zero
	localparam logic [31:0] FLAG_MASK     = 32'h0000037F;
	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [31:0] RST_FLAGS     = 32'h00000000;
	localparam logic [31:0] RST_ENABLE    = 32'h00000000;
	localparam logic        RST_GLOBAL    = 1'b0;
	localparam logic [1:0]  FATAL_FAILS   = 2'h3;
	localparam logic [2:0]  HSIZE_WORD    = 3'h2;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  HRESP_OKAY    = 2'h0;
endpackage : lesf_pkg

// >>> rtl/lesf_err_mem.sv
// Storage for queued error response words, registered read port
`timescale 1ns/1ns
module lesf_err_mem #(
	parameter int DW = 16,
	parameter int AW = 2
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read register with write bypass, so a word pushed into an empty queue is seen next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else if (we && (waddr == raddr)) begin
			rdata <= wdata;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : lesf_err_mem

// >>> rtl/lesf_rx_check.sv
// Received packet header checks: sequence, length pair and checksum
`timescale 1ns/1ns
module lesf_rx_check #(
	parameter int          SW      = 3,
	parameter int          LW      = 5,
	parameter logic [4:0]  MAX_LEN = 5'h09
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          rx_valid,
	input  wire logic [SW-1:0] sequence_number_field,
	input  wire logic [LW-1:0] packet_length_field,
	input  wire logic [LW-1:0] duplicate_length_field,
	input  wire logic          crc_ok,
	output logic               seq_err,
	output logic               len_err,
	output logic               crc_err
);
	logic [SW-1:0] last_seq_r;
	logic          have_seq_r;

	// One-cycle error pulses; the first packet only seeds the sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_seq_r <= '0;
			have_seq_r <= 1'b0;
			seq_err    <= 1'b0;
			len_err    <= 1'b0;
			crc_err    <= 1'b0;
		end else begin
			seq_err <= rx_valid && have_seq_r &&
				(sequence_number_field != SW'(last_seq_r + 1'b1));
			len_err <= rx_valid && ((packet_length_field != duplicate_length_field) ||
				(packet_length_field == '0) || (packet_length_field > LW'(MAX_LEN)));
			crc_err <= rx_valid && !crc_ok;
			if (rx_valid) begin
				last_seq_r <= sequence_number_field;
				have_seq_r <= 1'b1;
			end
		end
	end
endmodule : lesf_rx_check

// >>> rtl/lesf_top.sv
// Link event status flags with AHB-Lite register access and interrupt
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - Bit 9 set when credits reach zero
// - No requests issued while credits are zero
// - Bit 9 updates only after first credit return
// - Every flag can raise the interrupt
// - Bit 8 set when retry buffer fills
// - No requests while retry buffer is full
// - Bit 6 set on error queue overflow
// - Drop error responses until a read frees space
// - Bit 5 set on each error response
// - Bit 4 set after three failed retries
// - Bit 3 set on valid retry start
// - Bit 2 set on sequence step error
// - Bit 1 set on bad length pair
// - Bit 0 set on checksum failure
// - Writing one clears only that flag
// - Interrupt needs flag enable and global enable
module lesf_top #(
	parameter int CW     = 10,
	parameter int DW     = 16,
	parameter int QAW    = 2,
	parameter int ADDR_W = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic      [1:0]        hresp,
	input  wire logic              credit_return_packet,
	input  wire logic [CW-1:0]     credit_return_count,
	input  wire logic              request_sent,
	input  wire logic [CW-1:0]     request_credit_cost,
	input  wire logic              retry_buf_full,
	input  wire logic              err_resp_valid,
	input  wire logic [DW-1:0]     err_resp_data,
	input  wire logic              retry_attempt_fail,
	input  wire logic              retry_attempt_ok,
	input  wire logic              retry_start_packet,
	input  wire logic              rx_valid,
	input  wire logic [2:0]        sequence_number_field,
	input  wire logic [4:0]        packet_length_field,
	input  wire logic [4:0]        duplicate_length_field,
	input  wire logic              rx_crc_ok,
	output logic                   request_allowed,
	output logic                   irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------
	// Bus data phase capture
	// ----------------------------------------
	logic              dp_valid_r;
	logic              dp_write_r;
	logic [ADDR_W-1:0] dp_addr_r;
	logic              addr_phase;

	assign addr_phase = hsel && hready && (htrans == lesf_pkg::HTRANS_NONSEQ);

	// Address phase is held for the data phase; writes land in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= '0;
		end else begin
			dp_valid_r <= addr_phase;
			dp_write_r <= hwrite && (hsize == lesf_pkg::HSIZE_WORD);
			dp_addr_r  <= haddr;
		end
	end

	logic wr_status;
	logic wr_enable;
	logic wr_global;
	logic rd_errq;

	assign wr_status = dp_valid_r && dp_write_r && (dp_addr_r == ADDR_W'(lesf_pkg::OFS_STATUS));
	assign wr_enable = dp_valid_r && dp_write_r && (dp_addr_r == ADDR_W'(lesf_pkg::OFS_ENABLE));
	assign wr_global = dp_valid_r && dp_write_r && (dp_addr_r == ADDR_W'(lesf_pkg::OFS_GLOBAL));
	assign rd_errq   = addr_phase && !hwrite && (haddr == ADDR_W'(lesf_pkg::OFS_ERRQ));

	// ----------------------------------------
	// Credit tracking
	// ----------------------------------------
	logic [CW-1:0] credits_r;
	logic [CW-1:0] credits_nxt;
	logic          started_r;

	always_comb begin
		credits_nxt = credits_r;
		if (credit_return_packet) begin
			credits_nxt = CW'(credits_nxt + credit_return_count);
		end
		if (request_sent) begin
			credits_nxt = CW'(credits_nxt - request_credit_cost);
		end
	end

	// Credits track from reset; started_r arms the zero-credit flag on the first credit return
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			credits_r <= '0;
			started_r <= 1'b0;
		end else begin
			credits_r <= credits_nxt;
			if (credit_return_packet) begin
				started_r <= 1'b1;
			end
		end
	end

	// Requests gated on credits and retry buffer space; a slow-down, not an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			request_allowed <= 1'b0;
		end else begin
			request_allowed <= (credits_nxt != '0) && !retry_buf_full;
		end
	end

	// ----------------------------------------
	// Retry tracking
	// ----------------------------------------
	logic       rtb_full_q;
	logic [1:0] fail_cnt_r;

	// Consecutive failures saturate at three; any success restarts the count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rtb_full_q <= 1'b0;
			fail_cnt_r <= 2'h0;
		end else begin
			rtb_full_q <= retry_buf_full;
			if (retry_attempt_ok) begin
				fail_cnt_r <= 2'h0;
			end else if (retry_attempt_fail && (fail_cnt_r != lesf_pkg::FATAL_FAILS)) begin
				fail_cnt_r <= fail_cnt_r + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// Receive checks
	// ----------------------------------------
	logic seq_err;
	logic len_err;
	logic crc_err;

	lesf_rx_check u_rx_check (
		.clk                    (hclk),
		.rst_n                  (hresetn),
		.rx_valid               (rx_valid),
		.sequence_number_field  (sequence_number_field),
		.packet_length_field    (packet_length_field),
		.duplicate_length_field (duplicate_length_field),
		.crc_ok                 (rx_crc_ok),
		.seq_err                (seq_err),
		.len_err                (len_err),
		.crc_err                (crc_err)
	);

	// ----------------------------------------
	// Error response queue
	// ----------------------------------------
	logic [QAW-1:0] wr_ptr_r;
	logic [QAW-1:0] rd_ptr_r;
	logic [QAW:0]   q_count_r;
	logic           drop_r;
	logic           q_full;
	logic           q_push;
	logic           q_pop;
	logic           q_ovf;
	logic [DW-1:0]  q_head;

	assign q_full = (q_count_r == (QAW+1)'(2**QAW));
	assign q_pop  = rd_errq && (q_count_r != '0);
	assign q_push = err_resp_valid && (!q_full || q_pop) && !drop_r; // A pop in the same cycle makes room
	assign q_ovf  = err_resp_valid && q_full && !q_pop;

	// After an overflow, arrivals are dropped until a read frees space
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr_r  <= '0;
			rd_ptr_r  <= '0;
			q_count_r <= '0;
			drop_r    <= 1'b0;
		end else begin
			if (q_push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (q_pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			q_count_r <= q_count_r + (QAW+1)'(q_push) - (QAW+1)'(q_pop);
			if (q_pop) begin
				drop_r <= 1'b0;
			end else if (q_ovf) begin
				drop_r <= 1'b1;
			end
		end
	end

	lesf_err_mem #(
		.DW (DW),
		.AW (QAW)
	) u_err_mem (
		.clk   (hclk),
		.rst_n (hresetn),
		.we    (q_push),
		.waddr (wr_ptr_r),
		.wdata (err_resp_data),
		.raddr (rd_ptr_r),
		.rdata (q_head)
	);

	// ----------------------------------------
	// Event flags, enables, interrupt
	// ----------------------------------------
	logic [31:0] flags_r;
	logic [31:0] enable_r;
	logic        global_r;
	logic [31:0] set_vec;
	logic [31:0] clr_vec;

	always_comb begin
		set_vec = '0;
		set_vec[lesf_pkg::BIT_NO_CREDIT] = started_r && (credits_r == '0);
		set_vec[lesf_pkg::BIT_RTB_FULL]  = retry_buf_full && !rtb_full_q;
		set_vec[lesf_pkg::BIT_ERQ_OVF]   = q_ovf;
		set_vec[lesf_pkg::BIT_ERQ_RX]    = err_resp_valid;
		set_vec[lesf_pkg::BIT_FATAL]     = retry_attempt_fail && !retry_attempt_ok &&
			(fail_cnt_r >= (lesf_pkg::FATAL_FAILS - 2'h1));
		set_vec[lesf_pkg::BIT_REMOTE]    = retry_start_packet;
		set_vec[lesf_pkg::BIT_SEQ]       = seq_err;
		set_vec[lesf_pkg::BIT_LEN]       = len_err;
		set_vec[lesf_pkg::BIT_CRC]       = crc_err;
	end

	assign clr_vec = wr_status ? hwdata : '0;

	// Set wins over a clear in the same cycle, so no event is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_r <= lesf_pkg::RST_FLAGS;
		end else begin
			flags_r <= ((flags_r & ~clr_vec) | set_vec) & lesf_pkg::FLAG_MASK;
		end
	end

	// Enable and global gate registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_r <= lesf_pkg::RST_ENABLE;
			global_r <= lesf_pkg::RST_GLOBAL;
		end else begin
			if (wr_enable) begin
				enable_r <= hwdata & lesf_pkg::FLAG_MASK;
			end
			if (wr_global) begin
				global_r <= hwdata[lesf_pkg::BIT_GLOBAL];
			end
		end
	end

	// Any flag, informational or not, may interrupt; one cycle behind the flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= global_r && |(flags_r & enable_r);
		end
	end

	// ----------------------------------------
	// Read data and response
	// ----------------------------------------
	// Zero wait states; unmapped offsets read zero with an OKAY answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= '0;
			hreadyout <= 1'b1;
			hresp     <= lesf_pkg::HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= lesf_pkg::HRESP_OKAY;
			hrdata    <= '0;
			if (addr_phase && !hwrite) begin
				case (haddr)
					ADDR_W'(lesf_pkg::OFS_STATUS): hrdata <= flags_r;
					ADDR_W'(lesf_pkg::OFS_ENABLE): hrdata <= enable_r;
					ADDR_W'(lesf_pkg::OFS_GLOBAL): hrdata <= {31'h0, global_r};
					ADDR_W'(lesf_pkg::OFS_ERRQ): begin
						hrdata <= 32'(q_head);
						hrdata[lesf_pkg::BIT_ERQ_VALID] <= (q_count_r != '0);
					end
					default: hrdata <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_clr_crc;
		wr_status && hwdata[0] && !crc_err;
	endsequence
	sequence s_fail3;
		(fail_cnt_r == 2'h2) && retry_attempt_fail && !retry_attempt_ok;
	endsequence
	sequence s_full_arrival;
		err_resp_valid && q_full && !rd_errq;
	endsequence

	property p_err_rx;
		err_resp_valid |=> flags_r[5];
	endproperty
	a_err_rx: assert property (p_err_rx) else $error("error response flag not set");

	property p_crc;
		rx_valid && !rx_crc_ok |=> ##1 flags_r[0];
	endproperty
	a_crc: assert property (p_crc) else $error("checksum flag not set");

	property p_w1c;
		s_clr_crc |=> !flags_r[0] && ((($past(flags_r[9:1]) & ~$past(hwdata[9:1])) & ~flags_r[9:1]) == 9'h000);
	endproperty
	a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

	property p_gate;
		!global_r |=> !irq;
	endproperty
	a_gate: assert property (p_gate) else $error("interrupt without global enable");

	property p_irq_any;
		global_r && enable_r[2] && flags_r[2] ##1 global_r |-> irq;
	endproperty
	a_irq_any: assert property (p_irq_any) else $error("enabled flag did not interrupt");

	property p_sticky;
		flags_r[3] && !wr_status |=> flags_r[3];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

	property p_reserved;
		flags_r[10] == 1'b0 && flags_r[7] == 1'b0 && enable_r[7] == 1'b0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

	property p_armed;
		$rose(flags_r[9]) |-> $past(started_r);
	endproperty
	a_armed: assert property (p_armed) else $error("credit flag before first return");

	property p_fatal;
		s_fail3 |=> flags_r[4];
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal flag missing after three fails");

	property p_ovf;
		s_full_arrival |=> flags_r[6] && drop_r;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not flagged");

	property p_drop;
		drop_r && !rd_errq |=> $stable(wr_ptr_r);
	endproperty
	a_drop: assert property (p_drop) else $error("arrival stored while dropping");

	property p_hold;
		retry_buf_full |=> !request_allowed;
	endproperty
	a_hold: assert property (p_hold) else $error("request allowed with retry buffer full");

	property p_no_credit;
		credits_r == '0 && !credit_return_packet |=> !request_allowed;
	endproperty
	a_no_credit: assert property (p_no_credit) else $error("request allowed without credits");
endmodule : lesf_top

// >>> verification/lesf_link_model.sv
// Far-side link model: the memory device and link events seen by the flag block
`timescale 1ns/1ns
module lesf_link_model (
	input  wire logic hclk,
	output logic      credit_return_packet,
	output logic [9:0] credit_return_count,
	output logic      request_sent,
	output logic [9:0] request_credit_cost,
	output logic      retry_buf_full,
	output logic      err_resp_valid,
	output logic [15:0] err_resp_data,
	output logic      retry_attempt_fail,
	output logic      retry_attempt_ok,
	output logic      retry_start_packet,
	output logic      rx_valid,
	output logic [2:0] sequence_number_field,
	output logic [4:0] packet_length_field,
	output logic [4:0] duplicate_length_field,
	output logic      rx_crc_ok
);
	// ----------------------------------------
	// Idle link
	// ----------------------------------------
	initial begin
		{credit_return_packet, request_sent, retry_buf_full, err_resp_valid} = 4'h0;
		{retry_attempt_fail, retry_attempt_ok, retry_start_packet, rx_valid} = 4'h0;
		{credit_return_count, request_credit_cost, err_resp_data} = 36'h0;
		{sequence_number_field, packet_length_field, duplicate_length_field, rx_crc_ok} = 14'h0;
	end
	// One event per call, strobes one cycle wide; fields go to the inverse when released,
	// so a design that samples them late cannot see the old value by chance
	task automatic ev(input int k, input logic [15:0] v);
		@(posedge hclk);
		case (k)
			0: begin credit_return_packet <= 1'b1; credit_return_count <= v[9:0]; end
			1: begin request_sent <= 1'b1; request_credit_cost <= v[9:0]; end
			2: begin err_resp_valid <= 1'b1; err_resp_data <= v; end
			3: retry_attempt_fail <= 1'b1;
			4: retry_attempt_ok <= 1'b1;
			5: retry_start_packet <= 1'b1;
			6: begin
				rx_valid               <= 1'b1;
				sequence_number_field  <= v[2:0];
				packet_length_field    <= v[7:3];
				duplicate_length_field <= v[12:8];
				rx_crc_ok              <= v[13];
			end
			default: retry_buf_full <= v[0];
		endcase
		@(posedge hclk);
		{credit_return_packet, request_sent, err_resp_valid} <= 3'h0;
		{retry_attempt_fail, retry_attempt_ok, retry_start_packet, rx_valid} <= 4'h0;
		{credit_return_count, request_credit_cost} <= ~{credit_return_count, request_credit_cost};
		err_resp_data <= ~err_resp_data;
		{sequence_number_field, packet_length_field, duplicate_length_field, rx_crc_ok} <=
			~{sequence_number_field, packet_length_field, duplicate_length_field, rx_crc_ok};
	endtask : ev
endmodule : lesf_link_model

// >>> verification/testbench.sv
// Self-checking bench for the link event status flag block
`timescale 1ns/1ns
module testbench;
	localparam logic [7:0] A_ST = lesf_pkg::OFS_STATUS;
	localparam logic [7:0] A_EN = lesf_pkg::OFS_ENABLE;
	localparam logic [7:0] A_GL = lesf_pkg::OFS_GLOBAL;
	localparam logic [7:0] A_EQ = lesf_pkg::OFS_ERRQ;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, request_allowed, irq;
	logic [7:0]  haddr;
	logic [1:0]  htrans, hresp;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        credit_return_packet, request_sent, retry_buf_full, err_resp_valid, rx_valid, rx_crc_ok;
	logic        retry_attempt_fail, retry_attempt_ok, retry_start_packet, ok;
	logic [9:0]  credit_return_count, request_credit_cost;
	logic [15:0] err_resp_data;
	logic [2:0]  sequence_number_field;
	logic [4:0]  packet_length_field, duplicate_length_field, l, d;
	int          err_total, n_tests, cyc;

	lesf_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .credit_return_packet, .credit_return_count, .request_sent,
		.request_credit_cost, .retry_buf_full, .err_resp_valid, .err_resp_data, .retry_attempt_fail,
		.retry_attempt_ok, .retry_start_packet, .rx_valid, .sequence_number_field, .packet_length_field,
		.duplicate_length_field, .rx_crc_ok, .request_allowed, .irq);
	lesf_link_model link (.hclk, .credit_return_packet, .credit_return_count, .request_sent,
		.request_credit_cost, .retry_buf_full, .err_resp_valid, .err_resp_data, .retry_attempt_fail,
		.retry_attempt_ok, .retry_start_packet, .rx_valid, .sequence_number_field, .packet_length_field,
		.duplicate_length_field, .rx_crc_ok);

	// ----------------------------------------
	// Clock, hang guard and helpers
	// ----------------------------------------
	always #20 hclk = ~hclk;
	// The whole run needs well under a thousand cycles; the ceiling leaves ample margin
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// Single AHB-Lite transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz,
		output logic [31:0] v);
		hsel <= 1'b1; haddr <= a; hwrite <= w; hsize <= sz; htrans <= lesf_pkg::HTRANS_NONSEQ;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		v = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bus(1'b1, a, v, lesf_pkg::HSIZE_WORD, rd);
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, lesf_pkg::HSIZE_WORD, rd);
		chk(rd, exp);
		chk(32'(hresp), 32'(lesf_pkg::HRESP_OKAY));
	endtask : rchk
	// Interrupt follows a register change one cycle late, so let it land first
	task automatic ic(input logic exp);
		repeat (2) @(posedge hclk);
		chk(irq, exp);
	endtask : ic
	function automatic logic [31:0] fb(input int b);
		fb = 32'h1 << b;
	endfunction : fb
	function automatic logic [31:0] rx_exp(input logic [4:0] ln, input logic [4:0] dl, input logic good);
		rx_exp = 32'h0;
		rx_exp[lesf_pkg::BIT_LEN] = (ln != dl) || (ln == 5'h00) || (ln > 5'h09);
		rx_exp[lesf_pkg::BIT_CRC] = !good;
	endfunction : rx_exp
	// One event, flag and interrupt seen, then cleared by writing ones
	task automatic evt(input int k, input logic [15:0] v, input logic [31:0] exp);
		link.ev(k, v);
		repeat (2) @(posedge hclk);
		rchk(A_ST, exp);
		chk(irq, |exp);
		wr(A_ST, exp);
		rchk(A_ST, 32'h0);
		chk(irq, 1'b0);
	endtask : evt

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = 32'h0; err_total = 0; n_tests = 0; cyc = 0;
		void'($urandom(78174));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		// Credits are zero from reset, but no credit return has arrived yet
		rchk(A_ST, 32'h0);
		rchk(A_EN, 32'h0);
		rchk(A_GL, 32'h0);
		chk(request_allowed, 1'b0);
		wr(A_EN, 32'hFFFFFFFF);
		rchk(A_EN, lesf_pkg::FLAG_MASK);
		wr(A_EQ, 32'h0);
		rchk(A_EN, lesf_pkg::FLAG_MASK);
		wr(A_GL, 32'hFFFFFFFF);
		rchk(A_GL, 32'h1);
		wr(8'h00, 32'hFFFFFFFF);
		rchk(8'h00, 32'h0);
		// Credits and retry buffer gate requests
		link.ev(0, 16'h0005);
		repeat (2) @(posedge hclk);
		chk(request_allowed, 1'b1);
		link.ev(7, 16'h0001);
		repeat (2) @(posedge hclk);
		chk(request_allowed, 1'b0);
		link.ev(5, 16'h0000);
		link.ev(7, 16'h0000);
		repeat (2) @(posedge hclk);
		chk(request_allowed, 1'b1);
		rchk(A_ST, fb(lesf_pkg::BIT_RTB_FULL) | fb(lesf_pkg::BIT_REMOTE));
		wr(A_ST, fb(lesf_pkg::BIT_REMOTE));
		rchk(A_ST, fb(lesf_pkg::BIT_RTB_FULL));
		wr(A_EN, fb(lesf_pkg::BIT_REMOTE));
		ic(1'b0);
		wr(A_EN, fb(lesf_pkg::BIT_RTB_FULL));
		ic(1'b1);
		wr(A_GL, 32'h0);
		ic(1'b0);
		wr(A_GL, 32'h1);
		wr(A_EN, 32'hFFFFFFFF);
		wr(A_ST, 32'hFFFFFFFF);
		link.ev(1, 16'h0005);
		repeat (2) @(posedge hclk);
		chk(request_allowed, 1'b0);
		rchk(A_ST, fb(lesf_pkg::BIT_NO_CREDIT));
		wr(A_ST, fb(lesf_pkg::BIT_NO_CREDIT));
		rchk(A_ST, fb(lesf_pkg::BIT_NO_CREDIT));
		link.ev(0, 16'h0003);
		wr(A_ST, fb(lesf_pkg::BIT_NO_CREDIT));
		rchk(A_ST, 32'h0);
		// Only consecutive failures count toward the fatal flag
		link.ev(3, 16'h0000);
		link.ev(3, 16'h0000);
		link.ev(4, 16'h0000);
		link.ev(3, 16'h0000);
		link.ev(3, 16'h0000);
		rchk(A_ST, 32'h0);
		evt(3, 16'h0000, fb(lesf_pkg::BIT_FATAL));
		evt(5, 16'h0000, fb(lesf_pkg::BIT_REMOTE));
		// Clean packets through a sequence wrap, then a skipped number
		for (int i = 0; i < 10; i++) link.ev(6, {2'h0, 1'b1, 5'h04, 5'h04, 3'(i)});
		repeat (2) @(posedge hclk);
		rchk(A_ST, 32'h0);
		evt(6, {2'h0, 1'b1, 5'h04, 5'h04, 3'h4}, fb(lesf_pkg::BIT_SEQ));
		// Queue of four: fifth and sixth arrivals are dropped until a pop frees room
		for (int i = 0; i < 6; i++) link.ev(2, 16'hA000 + 16'(i));
		rchk(A_ST, fb(lesf_pkg::BIT_ERQ_RX) | fb(lesf_pkg::BIT_ERQ_OVF));
		rchk(A_EQ, 32'h8000A000);
		link.ev(2, 16'hB000);
		rchk(A_EQ, 32'h8000A001);
		rchk(A_EQ, 32'h8000A002);
		rchk(A_EQ, 32'h8000A003);
		rchk(A_EQ, 32'h8000B000);
		bus(1'b0, A_EQ, 32'h0, lesf_pkg::HSIZE_WORD, rd);
		chk(rd & 32'h80000000, 32'h0);
		wr(A_ST, 32'hFFFFFFFF);
		// Random length pairs and checksum results; sequence bit is left out after the skip above
		for (int i = 0; i < 40; i++) begin
			l = 5'($urandom_range(11, 0));
			d = ($urandom_range(2, 0) == 0) ? 5'($urandom_range(11, 0)) : l;
			ok = 1'($urandom_range(1, 0));
			link.ev(6, {2'h0, ok, d, l, 3'(i)});
			repeat (2) @(posedge hclk);
			bus(1'b0, A_ST, 32'h0, lesf_pkg::HSIZE_WORD, rd);
			chk(rd & 32'h3, rx_exp(l, d, ok));
			wr(A_ST, 32'h7);
		end
		report_and_stop();
	end
endmodule : testbench
